/* File: hdl/apf_fault_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module apf_fault_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire apf_pkg::apf_det_t detIn,
  input wire logic biasSelect,
  input wire logic resetIn_n,
  output var apf_pkg::apf_stage_t stageOut,
  output logic shutdownFlagO_n,
  output logic shutdownFlagOe,
  input wire logic shutdownFlagI_n,
  output logic overtempWarnO_n,
  output logic overtempWarnOe,
  input wire logic overtempWarnI_n
);

  function automatic logic apf_hit(input logic [3:0] adr,
                                   input logic [3:0] ofs);
    apf_hit = (adr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Detector synchronisers

  apf_pkg::apf_det_t detSync;

  apf_sync_bank #(
    .W($bits(apf_pkg::apf_det_t))
  ) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(detIn),
    .syncOut(detSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fault evaluation

  logic ocAny;
  logic supplyLowGuard;
  logic faultShut;
  logic running;
  logic resetRise;
  logic [16:0] olCntPlus;
  logic olHit;

  logic [15:0] olCnt_r;
  logic [15:0] olCnt_nxt;
  logic overloadLatch_r;
  logic overloadLatch_nxt;
  logic resetPrev_r;
  logic resetPrev_nxt;
  logic [15:0] olThresh_r;
  logic [15:0] olThresh_nxt;

  always_comb begin
    ocAny = |detSync.overcurrentTrip;
    // Either supply low raises the one shared guard
    supplyLowGuard = ~(detSync.gateDriveSupplyOk &
                       detSync.coreSupplyOk);
    resetRise = resetIn_n & ~resetPrev_r;
    resetPrev_nxt = resetIn_n;
    olCntPlus = {1'b0, olCnt_r} + 17'h1;
    // Count includes the current cycle of overcurrent
    olHit = ocAny & (olCntPlus >= {1'b0, olThresh_r});
    if (!ocAny) begin
      olCnt_nxt = 16'h0000;
    end else if (olCnt_r == apf_pkg::OL_CNT_MAX) begin
      olCnt_nxt = olCnt_r;
    end else begin
      olCnt_nxt = olCntPlus[15:0];
    end
    // Set wins over the reset-edge clear
    if (olHit) begin
      overloadLatch_nxt = 1'b1;
    end else if (resetRise) begin
      overloadLatch_nxt = 1'b0;
    end else begin
      overloadLatch_nxt = overloadLatch_r;
    end
    // Thermal and supply faults are not stored: they end with the cause
    faultShut = overloadLatch_r | detSync.thermalShutdown |
                supplyLowGuard;
    running = resetIn_n & ~faultShut;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      olCnt_r <= 16'h0000;
      overloadLatch_r <= 1'b0;
      // Held high so a clear with the pin already high makes no edge
      resetPrev_r <= 1'b1;
    end else begin
      olCnt_r <= olCnt_nxt;
      overloadLatch_r <= overloadLatch_nxt;
      resetPrev_r <= resetPrev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power stage and fault pins

  apf_pkg::apf_stage_t stage_r;
  apf_pkg::apf_stage_t stage_nxt;
  logic shutAssert_r;
  logic shutAssert_nxt;
  logic warnAssert_r;
  logic warnAssert_nxt;

  always_comb begin
    // First group needs reset high and no fault; second also needs bias-select
    stage_nxt.bridgeEn[2:0] = {3{running}};
    stage_nxt.bridgeEn[5:3] = {3{running & biasSelect}};
    // Per-bridge limiting follows the detector of that bridge
    stage_nxt.currentLimit = detSync.overcurrentTrip;
    // Pre-charge only while switching is held off
    stage_nxt.biasPrechargeCtl = ~resetIn_n & biasSelect &
                                 ~supplyLowGuard;
    shutAssert_nxt = resetIn_n & faultShut;
    warnAssert_nxt = resetIn_n & (detSync.tempWarn |
                                  detSync.thermalShutdown);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_r <= '0;
      shutAssert_r <= 1'b0;
      warnAssert_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      shutAssert_r <= shutAssert_nxt;
      warnAssert_r <= warnAssert_nxt;
    end
  end

  assign stageOut = stage_r;
  // Open drain: drive low only while asserting
  assign shutdownFlagO_n = 1'b0;
  assign shutdownFlagOe = shutAssert_r;
  assign overtempWarnO_n = 1'b0;
  assign overtempWarnOe = warnAssert_r;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic wbReq;
  logic wbWrite;
  logic [31:0] rdMux;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;

  always_comb begin
    wbReq = wb_cyc_i & wb_stb_i;
    ack_nxt = wbReq & ~ack_r;
    // Writes land on the edge where the master sees ack
    wbWrite = wbReq & ack_r & wb_we_i;
    rdMux = 32'h0000_0000;
    if (apf_hit(wb_adr_i, apf_pkg::OFS_CTRL)) begin
      rdMux[15:0] = olThresh_r;
    end else if (apf_hit(wb_adr_i, apf_pkg::OFS_STATUS)) begin
      rdMux[apf_pkg::ST_LATCH] = overloadLatch_r;
      rdMux[apf_pkg::ST_SUPPLY_LOW] = supplyLowGuard;
      rdMux[apf_pkg::ST_THERMAL] = detSync.thermalShutdown;
      rdMux[apf_pkg::ST_TEMP_WARN] = detSync.tempWarn;
      rdMux[apf_pkg::ST_OVERCURRENT] = ocAny;
      rdMux[apf_pkg::ST_SHUT_PIN] = shutdownFlagI_n;
      rdMux[apf_pkg::ST_RESET_IN] = resetIn_n;
      rdMux[apf_pkg::ST_BIAS_SEL] = biasSelect;
      rdMux[apf_pkg::ST_BRIDGE_LSB +: 6] = stage_r.bridgeEn;
      rdMux[apf_pkg::ST_BIAS_EN] = stage_r.biasPrechargeCtl;
      rdMux[apf_pkg::ST_WARN_PIN] = overtempWarnI_n;
    end else if (apf_hit(wb_adr_i, apf_pkg::OFS_OLCOUNT)) begin
      rdMux[15:0] = olCnt_r;
    end
    rdData_nxt = ack_nxt ? rdMux : rdData_r;
    olThresh_nxt = olThresh_r;
    if (wbWrite && apf_hit(wb_adr_i, apf_pkg::OFS_CTRL)) begin
      if (wb_sel_i[0]) begin
        olThresh_nxt[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        olThresh_nxt[15:8] = wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdData_r <= 32'h0000_0000;
      olThresh_r <= apf_pkg::OL_THRESH_RST;
    end else begin
      ack_r <= ack_nxt;
      rdData_r <= rdData_nxt;
      olThresh_r <= olThresh_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence sOverloadSet;
    ocAny && (olCntPlus >= {1'b0, olThresh_r}) ##1 overloadLatch_r;
  endsequence

  sequence sStageDark;
    stageOut.bridgeEn == 6'h00;
  endsequence

  a_limit_follow:
    assert property (detSync.overcurrentTrip != 6'h00 |=>
      stageOut.currentLimit == $past(detSync.overcurrentTrip))
    else $error("current limit does not follow detectors");

  a_overload_hiz:
    assert property (sOverloadSet |=> sStageDark)
    else $error("overload did not put the stage in Hi-Z");

  a_warn_drive:
    assert property (detSync.tempWarn && resetIn_n && !faultShut |=>
      overtempWarnOe && !shutdownFlagOe && stageOut.bridgeEn[2:0] == 3'b111)
    else $error("warning pin not driven on high temperature");

  a_thermal_hiz:
    assert property (detSync.thermalShutdown && resetIn_n |=>
      sStageDark and shutdownFlagOe)
    else $error("thermal shutdown did not stop the stage");

  a_por_clear:
    assert property (@(posedge clk) disable iff (1'b0)
      sys_rst |=> !overloadLatch_r && stageOut.bridgeEn == 6'h00)
    else $error("power-on clear left the latch or stage set");

  a_supply_hiz:
    assert property (supplyLowGuard |=> sStageDark)
    else $error("supply low did not stop the stage");

  a_self_resume:
    assert property (!faultShut && resetIn_n && biasSelect |=>
      stageOut.bridgeEn == 6'h3f && !shutdownFlagOe)
    else $error("stage did not resume without fault");

  a_reset_hold:
    assert property (!resetIn_n [*2] |-> sStageDark and !shutdownFlagOe
      and !overtempWarnOe)
    else $error("reset low did not hold outputs quiet");

  a_latch_edge:
    assert property (resetIn_n && !resetPrev_r && !olHit |=>
      !overloadLatch_r)
    else $error("reset rising edge did not clear overload latch");

  a_latch_hold:
    assert property (overloadLatch_r && !resetRise |=> overloadLatch_r)
    else $error("overload latch cleared without reset edge");

  a_bias_mode:
    assert property (!resetIn_n && biasSelect && !supplyLowGuard |=>
      stageOut.biasPrechargeCtl && stageOut.bridgeEn == 6'h00)
    else $error("pre-charge mode output pattern wrong");

  a_idle_dark:
    assert property (!resetIn_n && !biasSelect |=>
      sStageDark and !stageOut.biasPrechargeCtl)
    else $error("idle mode drove bias or bridges");

  a_all_switch:
    assert property (resetIn_n && biasSelect && !faultShut |=>
      stageOut.bridgeEn == 6'h3f && !stageOut.biasPrechargeCtl)
    else $error("full mode did not switch all six channels");

  a_group_split:
    assert property (resetIn_n && !biasSelect |=>
      stageOut.bridgeEn[5:3] == 3'b000 && !stageOut.biasPrechargeCtl)
    else $error("second group switched with bias-select low");

  a_count_clear:
    assert property (!ocAny |=> olCnt_r == 16'h0000 && !$rose(overloadLatch_r))
    else $error("overload count not cleared by quiet detector");

  a_wb_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

/* File: include/apf_pkg.sv */
package apf_pkg;

  localparam int TEMP_WARN_C = 125;
  localparam int TEMP_SHUT_C = 155;
  localparam int SUPPLY_GOOD_MV = 10000;

  localparam int BRIDGES = 6;
  localparam int GROUP_W = 3;
  localparam int SYNC_STAGES = 2;

  localparam int WB_ADR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_OLCOUNT = 4'h8;

  localparam int OL_W = 16;
  localparam logic [15:0] OL_THRESH_RST = 16'h0400;
  localparam logic [15:0] OL_CNT_MAX = 16'hffff;

  localparam int ST_LATCH = 0;
  localparam int ST_SUPPLY_LOW = 1;
  localparam int ST_THERMAL = 2;
  localparam int ST_TEMP_WARN = 3;
  localparam int ST_OVERCURRENT = 4;
  localparam int ST_SHUT_PIN = 5;
  localparam int ST_RESET_IN = 6;
  localparam int ST_BIAS_SEL = 7;
  localparam int ST_BRIDGE_LSB = 8;
  localparam int ST_BIAS_EN = 14;
  localparam int ST_WARN_PIN = 15;

  typedef struct packed {
    logic [5:0] overcurrentTrip;
    logic tempWarn;
    logic thermalShutdown;
    logic gateDriveSupplyOk;
    logic coreSupplyOk;
  } apf_det_t;

  typedef struct packed {
    logic [5:0] bridgeEn;
    logic [5:0] currentLimit;
    logic biasPrechargeCtl;
  } apf_stage_t;

endpackage

/* File: hdl/apf_sync_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module apf_sync_bank #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gBit
      always_comb begin
        meta_nxt[g] = asyncIn[g];
        sync_nxt[g] = meta_r[g];
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= meta_nxt[g];
          sync_r[g] <= sync_nxt[g];
        end
      end
    end
  endgenerate

  assign syncOut = sync_r;

  a_sync_two_stage:
    assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst, 2) |-> syncOut == $past(asyncIn, 2))
    else $error("synchroniser output is not input delayed by two");

endmodule
`default_nettype wire

/* File: bench/apf_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module apf_ctrl_model #(
  parameter int OL_WAIT = 16
) (
  input wire logic clk,
  input wire logic sdOe,
  input wire logic owOe,
  output logic sdPin_n,
  output logic owPin_n,
  output logic resetIn_n,
  output logic biasSelect
);
  // Open-drain pins with pull-up: released means high
  assign sdPin_n = !sdOe;
  assign owPin_n = !owOe;
  initial begin
    resetIn_n = 1'h0;
    biasSelect = 1'h0;
  end
  task automatic set_mode(input logic bs, input logic rn);
    @(posedge clk);
    biasSelect <= bs;
    resetIn_n <= rn;
  endtask
  // Pre-charge the bias before any switching starts
  task automatic start_up(input logic bs);
    set_mode(1'h1, 1'h0);
    repeat (8) @(posedge clk);
    set_mode(bs, 1'h1);
  endtask
  task automatic restart();
    repeat (OL_WAIT) @(posedge clk);
    set_mode(biasSelect, 1'h0);
    set_mode(biasSelect, 1'h1);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_apf_fault_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_apf_fault_ctrl;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
  } apf_note_t;
  logic clk = 1'h0;
  logic sysRst = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] datW = 32'h0;
  logic [31:0] datR;
  logic ack, sdOe, owOe, sdPin_n, owPin_n, resetIn_n, biasSelect;
  apf_pkg::apf_det_t det = 10'h003;
  apf_pkg::apf_stage_t stage;
  apf_note_t q[$];
  apf_note_t note;
  int n_fail = 0, comparisons = 0, seed = 32;
  logic [5:0] ocPat;
  logic [12:0] modeExp[4] = '{13'h0000, 13'h0380, 13'h0001, 13'h1f80};

  always #10 clk = ~clk;

  apf_fault_ctrl i_apf_fault_ctrl (.clk(clk), .sys_rst(sysRst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .detIn(det), .biasSelect(biasSelect), .resetIn_n(resetIn_n),
    .stageOut(stage), .shutdownFlagO_n(), .shutdownFlagOe(sdOe),
    .shutdownFlagI_n(sdPin_n), .overtempWarnO_n(), .overtempWarnOe(owOe),
    .overtempWarnI_n(owPin_n));
  apf_ctrl_model #(.OL_WAIT(16)) i_apf_ctrl_model (.clk(clk), .sdOe(sdOe),
    .owOe(owOe), .sdPin_n(sdPin_n), .owPin_n(owPin_n),
    .resetIn_n(resetIn_n), .biasSelect(biasSelect));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic look(input logic [12:0] st, input logic sd, input logic ow);
    check({17'h0, stage, sdPin_n, owPin_n}, {17'h0, st, sd, ow});
  endtask
  // Single classic cycle; reads note their expected data for the monitor
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    datW <= d;
    q.push_back('{d, w ? 32'h0 : m});
    @(posedge clk);
    while (ack !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) n_fail++;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic apply(input logic [9:0] v);
    @(posedge clk);
    det <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic mode(input logic bs, input logic rn);
    i_apf_ctrl_model.set_mode(bs, rn);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic overload();
    apply({ocPat, 4'h3});
    wb(1'h0, 4'h8, 4'hf, 32'h0003, 32'hffff_ffff);
    repeat (9) @(posedge clk);
    apply(10'h003);
  endtask

  always @(posedge clk) begin
    if (ack === 1'h1) begin
      if (q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        note = q.pop_front();
        check(datR & note.m, note.d & note.m);
      end
    end
  end

  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    sysRst <= 1'h0;
    @(posedge clk);
    #1;
    look(13'h0, 1'h1, 1'h1);
    wb(1'h0, 4'h0, 4'hf, 32'h0400, 32'hffff);
    wb(1'h1, 4'h0, 4'h1, 32'hffff_ff05, 32'h0);
    wb(1'h0, 4'h0, 4'hf, 32'h0405, 32'hffff_ffff);
    wb(1'h1, 4'h0, 4'h2, 32'h0, 32'h0);
    wb(1'h1, 4'h4, 4'hf, 32'hffff_ffff, 32'h0);
    wb(1'h0, 4'h0, 4'hf, 32'h0005, 32'hffff_ffff);
    wb(1'h0, 4'hc, 4'hf, 32'h0, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      mode(i[1], i[0]);
      look(modeExp[i], 1'h1, 1'h1);
    end
    i_apf_ctrl_model.start_up(1'h1);
    apply(10'h00b);
    look(13'h1f80, 1'h1, 1'h0);
    mode(1'h1, 1'h0);
    look(13'h0001, 1'h1, 1'h1);
    mode(1'h1, 1'h1);
    apply(10'h007);
    look(13'h0, 1'h0, 1'h0);
    apply(10'h003);
    look(13'h1f80, 1'h1, 1'h1);
    for (int i = 0; i < 2; i++) begin
      apply(i[0] ? 10'h001 : 10'h002);
      look(13'h0, 1'h0, 1'h1);
      apply(10'h003);
      look(13'h1f80, 1'h1, 1'h1);
    end
    apply(10'h001);
    mode(1'h1, 1'h0);
    look(13'h0, 1'h1, 1'h1);
    mode(1'h1, 1'h1);
    apply(10'h003);
    ocPat = 6'($random(seed));
    if (ocPat == 6'h0) ocPat = 6'h01;
    @(posedge clk);
    det <= {ocPat, 4'h3};
    repeat (3) @(posedge clk);
    det <= 10'h003;
    #1;
    look({6'h3f, ocPat, 1'h0}, 1'h1, 1'h1);
    repeat (4) @(posedge clk);
    #1;
    look(13'h1f80, 1'h1, 1'h1);
    overload();
    look(13'h0, 1'h0, 1'h1);
    wb(1'h0, 4'h4, 4'hf, 32'h1, 32'h1);
    i_apf_ctrl_model.restart();
    repeat (2) @(posedge clk);
    #1;
    look(13'h1f80, 1'h1, 1'h1);
    overload();
    @(posedge clk);
    sysRst <= 1'h1;
    repeat (2) @(posedge clk);
    sysRst <= 1'h0;
    repeat (5) @(posedge clk);
    #1;
    look(13'h1f80, 1'h1, 1'h1);
    wb(1'h0, 4'h4, 4'hf, 32'h0, 32'h1);
    wb(1'h0, 4'h0, 4'hf, 32'h0400, 32'hffff_ffff);
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
